// [rtl/rsc_radio_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Crystal-keep bit selects ready mode and keeps the crystal running.
// - Synth-keep bit selects tune mode, keeping the PLL enabled and locked.
// - Tune mode turns the crystal on even with crystal-keep bit clear.
// - Writing transmit request from any idle mode starts the transmit sequence.
// - Transmit: regulators, crystal wait, PLL, calibrate, settle, PA ramp, send.
// - Skip-calibration bit bypasses oscillator calibration; it resets to zero.
// - Steps already running in the idle mode are skipped.
// - Oscillator and PLL recalibrate every time the PLL is enabled, unless the skip-calibration bit is set.
// - Writing receive request from any idle mode starts the receive sequence.
// - Receive: regulators, crystal, PLL, calibrate, settle, front end, modem.
// - Receiving modem then runs gain, correction, sync and packet handling.
// - Status register: overflow, underflow, empty, header, frequency, power state.
// - Pending interrupt drives the active-low request output low.
// - Only events enabled in the two mask registers assert the request.
// - Request stays low until its status register is read.
// - Reading an event status register clears its enabled bits.
// - Disabled events still set status bits without asserting the request.
// - Event bit layout of the first and second status registers.
// - First mask resets to zero, second resets with power-on enable only.
// - After reset the device is in ready idle mode.
// - Writing zero to mode control selects standby.
// - Wake-up timer enable bit selects sleep mode.
module rsc_radio_ctrl #(
	parameter int unsigned XTAL_CYC = rsc_pkg::XTAL_START_CYC,
	parameter int unsigned PLL_CYC = rsc_pkg::PLL_SETTLE_CYC
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic spi_sclk,
	input wire logic spi_sel_n,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic interrupt_request_n,
	input wire logic [7:0] ev_first,
	input wire logic [7:0] ev_second,
	input wire logic [4:0] fifo_flags,
	input wire logic tx_packet_done,
	output logic ldo_main_en,
	output logic xtal_en,
	output logic pll_en,
	output logic vco_cal_en,
	output logic pa_en,
	output logic rx_front_en,
	output logic modem_rx_en,
	output logic modem_tx_en,
	output logic wake_timer_en,
	output logic xtal_buf_override,
	output logic [1:0] power_state
);
	import rsc_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic [2:0] sclk_s;
		logic [1:0] sel_s;
		logic [1:0] sdi_s;
		logic [3:0] bitcnt;
		logic [7:0] shin;
		logic [7:0] shout;
		logic rw;
		logic [6:0] addr;
		logic [7:0] ev1;
		logic [7:0] ev2;
		logic [7:0] m1;
		logic [7:0] m2;
		logic [7:0] mode;
		logic [7:0] seqcfg;
		logic [7:0] xctrl;
		rsc_seq_e seq;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] xcnt;
		logic xtal_rdy;
		logic pll_rdy;
	} rsc_state_s;

	localparam rsc_state_s ST_RST = '{
		sel_s: 2'h3, ev1: EV_FIRST_RST, ev2: EV_SECOND_RST,
		m1: MASK_FIRST_RST, m2: MASK_SECOND_RST, mode: MODE_CTRL_RST,
		seqcfg: SEQ_CFG_RST, xctrl: XTAL_CTRL_RST, seq: SEQ_IDLE, default: '0};

	rsc_state_s st_q;
	rsc_state_s st_d;
	logic rise;
	logic fall;
	logic clr1;
	logic clr2;
	logic [7:0] byte_in;
	logic [7:0] set1;
	logic [7:0] set2;
	logic want_tx;
	logic want_rx;
	logic want_pll;
	logic xtal_need;
	logic [7:0] dis_ev1;

	function automatic logic [7:0] rd_mux(input logic [6:0] a);
		logic [7:0] r;
		r = 8'h00;
		unique case (a)
			ADDR_DEV_STATUS: r = {fifo_flags, 1'b0, power_state};
			ADDR_EV_FIRST: r = st_q.ev1;
			ADDR_EV_SECOND: r = st_q.ev2;
			ADDR_MASK_FIRST: r = st_q.m1;
			ADDR_MASK_SECOND: r = st_q.m2;
			ADDR_MODE_CTRL: r = st_q.mode;
			ADDR_SEQ_CFG: r = st_q.seqcfg;
			ADDR_XTAL_CTRL: r = st_q.xctrl;
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	assign want_tx = st_q.mode[MODE_TX_REQ];
	assign want_rx = st_q.mode[MODE_RX_REQ];
	assign want_pll = want_tx | want_rx | st_q.mode[MODE_SYNTH_KEEP];
	assign xtal_need = st_q.mode[MODE_XTAL_KEEP] | want_pll;
	assign dis_ev1 = ev_first & ~st_q.m1;

	// ==========================================================
	// Outputs
	assign spi_sdo = st_q.shout[7];
	assign interrupt_request_n = ~|((st_q.ev1 & st_q.m1) | (st_q.ev2 & st_q.m2));
	assign ldo_main_en = xtal_need | (st_q.seq != SEQ_IDLE);
	assign xtal_en = xtal_need;
	assign pll_en = st_q.pll_rdy | (st_q.seq inside {SEQ_PLL_EN, SEQ_VCO_CAL, SEQ_PLL_SETTLE});
	assign vco_cal_en = st_q.seq == SEQ_VCO_CAL;
	assign pa_en = st_q.seq inside {SEQ_PA_RAMP, SEQ_TX_ACTIVE};
	assign rx_front_en = st_q.seq inside {SEQ_RX_FRONT, SEQ_RX_ACTIVE};
	assign modem_rx_en = st_q.seq == SEQ_RX_ACTIVE;
	assign modem_tx_en = st_q.seq == SEQ_TX_ACTIVE;
	assign wake_timer_en = st_q.mode[MODE_WAKE_TIMER];
	assign xtal_buf_override = st_q.xctrl[XTAL_BUF_OVR];
	assign power_state = (st_q.seq == SEQ_TX_ACTIVE) ? CPS_TX :
		(st_q.seq == SEQ_RX_ACTIVE) ? CPS_RX : CPS_IDLE;

	// ==========================================================
	// Next state
	always_comb begin
		st_d = st_q;
		clr1 = 1'b0;
		clr2 = 1'b0;
		set1 = ev_first;
		set2 = ev_second;
		byte_in = {st_q.shin[6:0], st_q.sdi_s[1]};
		// Pins are sampled twice, sclk three times; its edges compare the second and third stages
		st_d.sclk_s = {st_q.sclk_s[1:0], spi_sclk};
		st_d.sel_s = {st_q.sel_s[0], spi_sel_n};
		st_d.sdi_s = {st_q.sdi_s[0], spi_sdi};
		rise = st_q.sclk_s[1] & ~st_q.sclk_s[2];
		fall = ~st_q.sclk_s[1] & st_q.sclk_s[2];
		// Serial register port: one address byte, then data bytes with auto-increment
		if (st_q.sel_s[1]) begin
			st_d.bitcnt = 4'h0;
			st_d.shout = 8'h00;
		end else if (rise) begin
			st_d.shin = byte_in;
			st_d.bitcnt = (st_q.bitcnt == 4'hf) ? 4'h8 : st_q.bitcnt + 4'h1;
			if (st_q.bitcnt == 4'h7) begin
				st_d.rw = byte_in[7];
				st_d.addr = byte_in[6:0];
				if (!byte_in[7]) begin
					st_d.shout = rd_mux(byte_in[6:0]);
					clr1 = byte_in[6:0] == ADDR_EV_FIRST;
					clr2 = byte_in[6:0] == ADDR_EV_SECOND;
				end
			end else if (st_q.bitcnt == 4'hf) begin
				st_d.addr = st_q.addr + 7'h01;
				if (st_q.rw) begin
					unique case (st_q.addr)
						ADDR_MASK_FIRST: st_d.m1 = byte_in;
						ADDR_MASK_SECOND: st_d.m2 = byte_in;
						ADDR_MODE_CTRL: st_d.mode = byte_in;
						ADDR_SEQ_CFG: st_d.seqcfg = byte_in;
						ADDR_XTAL_CTRL: st_d.xctrl = byte_in;
						default: st_d.mode = st_d.mode;
					endcase
				end else begin
					st_d.shout = rd_mux(st_q.addr + 7'h01);
					clr1 = (st_q.addr + 7'h01) == ADDR_EV_FIRST;
					clr2 = (st_q.addr + 7'h01) == ADDR_EV_SECOND;
				end
			end
		end else if (fall && st_q.bitcnt != 4'h8) begin
			// Hold the freshly loaded MSB across the first falling edge
			st_d.shout = {st_q.shout[6:0], 1'b0};
		end
		// Crystal start-up timer runs in every mode that needs the crystal
		if (!xtal_need) begin
			st_d.xtal_rdy = 1'b0;
			st_d.xcnt = '0;
		end else if (!st_q.xtal_rdy) begin
			st_d.xcnt = st_q.xcnt + CNT_W'(1);
			if (st_q.xcnt == CNT_W'(XTAL_CYC - 1)) begin
				st_d.xtal_rdy = 1'b1;
				set2[EV2_CHIP_READY] = 1'b1;
			end
		end
		// Power-up sequencer
		unique case (st_q.seq)
			SEQ_IDLE: begin
				st_d.cnt = '0;
				if (!st_q.mode[MODE_SYNTH_KEEP]) begin
					st_d.pll_rdy = 1'b0;
				end
				if (want_tx || want_rx) begin
					if (st_q.pll_rdy) begin
						st_d.seq = want_tx ? SEQ_PA_RAMP : SEQ_RX_FRONT;
					end else if (st_q.xtal_rdy) begin
						st_d.seq = SEQ_PLL_EN;
					end else begin
						st_d.seq = SEQ_XTAL_WAIT;
					end
				end else if (st_q.mode[MODE_SYNTH_KEEP] && !st_q.pll_rdy) begin
					st_d.seq = st_q.xtal_rdy ? SEQ_PLL_EN : SEQ_XTAL_WAIT;
				end
			end
			SEQ_XTAL_WAIT: begin
				if (!want_pll) begin
					st_d.seq = SEQ_IDLE;
				end else if (st_q.xtal_rdy) begin
					st_d.seq = SEQ_PLL_EN;
				end
			end
			SEQ_PLL_EN: begin
				st_d.cnt = '0;
				// Every fresh PLL enable passes through calibration unless skipped
				st_d.seq = st_q.seqcfg[SEQ_SKIP_CAL] ? SEQ_PLL_SETTLE : SEQ_VCO_CAL;
				if (!want_pll) begin
					st_d.seq = SEQ_IDLE;
				end
			end
			SEQ_VCO_CAL: begin
				st_d.cnt = st_q.cnt + CNT_W'(1);
				if (!want_pll) begin
					st_d.seq = SEQ_IDLE;
				end else if (st_q.cnt == CNT_W'(VCO_CAL_CYC - 1)) begin
					st_d.cnt = '0;
					st_d.seq = SEQ_PLL_SETTLE;
				end
			end
			SEQ_PLL_SETTLE: begin
				st_d.cnt = st_q.cnt + CNT_W'(1);
				if (!want_pll) begin
					st_d.seq = SEQ_IDLE;
				end else if (st_q.cnt == CNT_W'(PLL_CYC - 1)) begin
					st_d.cnt = '0;
					st_d.pll_rdy = 1'b1;
					st_d.seq = want_tx ? SEQ_PA_RAMP : want_rx ? SEQ_RX_FRONT : SEQ_IDLE;
				end
			end
			SEQ_PA_RAMP: begin
				st_d.cnt = st_q.cnt + CNT_W'(1);
				if (!want_tx) begin
					st_d.seq = SEQ_IDLE;
				end else if (st_q.cnt == CNT_W'(PA_RAMP_CYC - 1)) begin
					st_d.seq = SEQ_TX_ACTIVE;
				end
			end
			SEQ_TX_ACTIVE: begin
				if (!want_tx) begin
					st_d.seq = SEQ_IDLE;
				end else if (tx_packet_done) begin
					st_d.seq = SEQ_IDLE;
					st_d.mode[MODE_TX_REQ] = 1'b0;
					set1[EV1_PKT_SENT] = 1'b1;
				end
			end
			SEQ_RX_FRONT: begin
				st_d.seq = want_rx ? SEQ_RX_ACTIVE : SEQ_IDLE;
			end
			SEQ_RX_ACTIVE: begin
				if (!want_rx) begin
					st_d.seq = SEQ_IDLE;
				end
			end
			default: st_d.seq = SEQ_IDLE;
		endcase
		// Event capture; a new event beats a read-clear in the same cycle
		st_d.ev1 = (st_q.ev1 & ~(clr1 ? st_q.m1 : 8'h00)) | set1;
		st_d.ev2 = (st_q.ev2 & ~(clr2 ? st_q.m2 : 8'h00)) | set2;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_q <= ST_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	property p_mask_reset;
		$past(sys_rst) |-> (st_q.m1 == 8'h00) && (st_q.m2 == 8'h01) && (st_q.mode == 8'h01);
	endproperty
	a_mask_reset: assert property (p_mask_reset) else $error("bad reset values");

	property p_irq_low;
		(|(set1 & st_q.m1 & st_d.m1)) |=> !interrupt_request_n;
	endproperty
	a_irq_low: assert property (p_irq_low) else $error("enabled event without request");

	property p_read_clear;
		(clr1 && ev_first == 8'h00 && !set1[EV1_PKT_SENT]) |=> (st_q.ev1 & $past(st_q.m1)) == 8'h00;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("read did not clear");

	property p_disabled_sets;
		(dis_ev1 != 8'h00) |=> (st_q.ev1 & $past(dis_ev1)) == $past(dis_ev1);
	endproperty
	a_disabled_sets: assert property (p_disabled_sets) else $error("disabled event lost");

	property p_tx_start;
		(st_q.seq == SEQ_IDLE && want_tx && !st_q.xtal_rdy && !st_q.pll_rdy)
			|=> st_q.seq == SEQ_XTAL_WAIT;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("transmit sequence not started");

	property p_tune_skip;
		(st_q.seq == SEQ_IDLE && want_tx && st_q.pll_rdy) |=> st_q.seq == SEQ_PA_RAMP;
	endproperty
	a_tune_skip: assert property (p_tune_skip) else $error("locked PLL not skipped");

	property p_skip_cal;
		(st_q.seq == SEQ_PLL_EN && st_q.seqcfg[SEQ_SKIP_CAL] && want_pll)
			|=> st_q.seq == SEQ_PLL_SETTLE;
	endproperty
	a_skip_cal: assert property (p_skip_cal) else $error("calibration not skipped");

	property p_ramp_wait;
		(st_q.seq == SEQ_PA_RAMP && want_tx && st_q.cnt != CNT_W'(PA_RAMP_CYC - 1))
			|=> st_q.seq == SEQ_PA_RAMP;
	endproperty
	a_ramp_wait: assert property (p_ramp_wait) else $error("ramp ended early");

	property p_tune_xtal;
		st_q.mode[MODE_SYNTH_KEEP] |-> xtal_en && ldo_main_en;
	endproperty
	a_tune_xtal: assert property (p_tune_xtal) else $error("tune without crystal");

	property p_tx_state;
		(st_q.seq == SEQ_TX_ACTIVE) |-> power_state == 2'h2 && pa_en && pll_en;
	endproperty
	a_tx_state: assert property (p_tx_state) else $error("transmit state wrong");
endmodule
`default_nettype wire

// [inc/rsc_pkg.sv]
`default_nettype none
package rsc_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [6:0] ADDR_DEV_STATUS = 7'h02;
	localparam logic [6:0] ADDR_EV_FIRST = 7'h03;
	localparam logic [6:0] ADDR_EV_SECOND = 7'h04;
	localparam logic [6:0] ADDR_MASK_FIRST = 7'h05;
	localparam logic [6:0] ADDR_MASK_SECOND = 7'h06;
	localparam logic [6:0] ADDR_MODE_CTRL = 7'h07;
	localparam logic [6:0] ADDR_SEQ_CFG = 7'h08;
	localparam logic [6:0] ADDR_XTAL_CTRL = 7'h62;
	// ==========================================================
	// Values after reset
	localparam logic [7:0] EV_FIRST_RST = 8'h00;
	localparam logic [7:0] EV_SECOND_RST = 8'h01;
	localparam logic [7:0] MASK_FIRST_RST = 8'h00;
	localparam logic [7:0] MASK_SECOND_RST = 8'h01;
	localparam logic [7:0] MODE_CTRL_RST = 8'h01;
	localparam logic [7:0] SEQ_CFG_RST = 8'h00;
	localparam logic [7:0] XTAL_CTRL_RST = 8'h00;
	// ==========================================================
	// Field positions
	localparam int MODE_XTAL_KEEP = 0;
	localparam int MODE_SYNTH_KEEP = 1;
	localparam int MODE_RX_REQ = 2;
	localparam int MODE_TX_REQ = 3;
	localparam int MODE_WAKE_TIMER = 6;
	localparam int SEQ_SKIP_CAL = 0;
	localparam int XTAL_BUF_OVR = 1;
	localparam int EV1_PKT_SENT = 2;
	localparam int EV2_CHIP_READY = 1;
	// ==========================================================
	// Power state codes
	localparam logic [1:0] CPS_IDLE = 2'h0;
	localparam logic [1:0] CPS_RX = 2'h1;
	localparam logic [1:0] CPS_TX = 2'h2;
	// ==========================================================
	// Sequencer timing
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned XTAL_START_US = 600;
	localparam int unsigned PLL_SETTLE_US = 100;
	localparam int unsigned VCO_CAL_US = 20;
	localparam int unsigned PA_RAMP_US = 5;
	localparam int unsigned XTAL_START_CYC = XTAL_START_US * CLK_MHZ;
	localparam int unsigned PLL_SETTLE_CYC = PLL_SETTLE_US * CLK_MHZ;
	localparam int unsigned VCO_CAL_CYC = VCO_CAL_US * CLK_MHZ;
	localparam int unsigned PA_RAMP_CYC = PA_RAMP_US * CLK_MHZ;
	localparam int CNT_W = 20;
	// ==========================================================
	// Sequencer states
	typedef enum logic [3:0] {
		SEQ_IDLE = 4'h0,
		SEQ_XTAL_WAIT = 4'h1,
		SEQ_PLL_EN = 4'h2,
		SEQ_VCO_CAL = 4'h3,
		SEQ_PLL_SETTLE = 4'h4,
		SEQ_PA_RAMP = 4'h5,
		SEQ_TX_ACTIVE = 4'h6,
		SEQ_RX_FRONT = 4'h7,
		SEQ_RX_ACTIVE = 4'h8
	} rsc_seq_e;
endpackage
`default_nettype wire

// [dv/rsc_host.sv]
`timescale 1ns/1ns
`default_nettype none
// ====================
// Host register master, mode 0; link clock stays low between frames
module rsc_host (
	input wire logic clock,
	output logic spi_sclk,
	output logic spi_sel_n,
	output logic spi_sdi,
	input wire logic spi_sdo,
	output logic rd_valid,
	output logic [7:0] rd_data
);
	initial begin
		spi_sclk = 1'b0;
		spi_sel_n = 1'b1;
		spi_sdi = 1'b0;
		rd_valid = 1'b0;
		rd_data = 8'h00;
	end
	// Read data is taken just before each rise, after the device shifted on the fall
	task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			spi_sdi = tx[i];
			#62;
			rx[i] = spi_sdo;
			spi_sclk = 1'b1;
			#63;
			spi_sclk = 1'b0;
		end
	endtask
	task automatic xfer(input logic [7:0] hdr, input logic [7:0] wd, output logic [7:0] rd);
		logic [7:0] dummy;
		spi_sel_n = 1'b0;
		#62;
		shift_byte(hdr, dummy);
		shift_byte(wd, rd);
		#62;
		spi_sel_n = 1'b1;
		// Released line must not hold a stale level
		spi_sdi = ~spi_sdi;
		#125;
		@(negedge clock);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] r;
		xfer({1'b1, a}, d, r);
	endtask
	task automatic rd(input logic [6:0] a);
		logic [7:0] r;
		xfer({1'b0, a}, 8'h00, r);
		@(posedge clock);
		rd_data <= r;
		rd_valid <= 1'b1;
		@(posedge clock);
		rd_valid <= 1'b0;
		@(negedge clock);
	endtask
endmodule
`default_nettype wire

// [dv/rsc_radio_ctrl_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module rsc_radio_ctrl_tb;
	import rsc_pkg::*;
	// Short crystal and settle counts keep the run brief
	localparam int XC = 20;
	localparam int PC = 10;
	typedef struct packed {
		logic [7:0] val;
		logic [7:0] mask;
	} rsc_exp_s;
	logic clock = 1'b0;
	logic sys_rst, spi_sclk, spi_sel_n, spi_sdi, spi_sdo, interrupt_request_n;
	logic [7:0] ev_first, ev_second, rd_data;
	logic [4:0] fifo_flags;
	logic tx_packet_done, ldo_main_en, xtal_en, pll_en, vco_cal_en, pa_en, rx_front_en;
	logic modem_rx_en, modem_tx_en, wake_timer_en, xtal_buf_override, rd_valid;
	logic [1:0] power_state;
	rsc_exp_s exp_q[$];
	rsc_exp_s e;
	int num_errors = 0;
	int check_count = 0;
	always #5 clock = ~clock;
	rsc_radio_ctrl #(.XTAL_CYC(XC), .PLL_CYC(PC)) i_dut (.clock(clock), .sys_rst(sys_rst),
		.spi_sclk(spi_sclk), .spi_sel_n(spi_sel_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
		.interrupt_request_n(interrupt_request_n), .ev_first(ev_first), .ev_second(ev_second),
		.fifo_flags(fifo_flags), .tx_packet_done(tx_packet_done), .ldo_main_en(ldo_main_en),
		.xtal_en(xtal_en), .pll_en(pll_en), .vco_cal_en(vco_cal_en), .pa_en(pa_en),
		.rx_front_en(rx_front_en), .modem_rx_en(modem_rx_en), .modem_tx_en(modem_tx_en),
		.wake_timer_en(wake_timer_en), .xtal_buf_override(xtal_buf_override),
		.power_state(power_state));
	rsc_host i_host (.clock(clock), .spi_sclk(spi_sclk), .spi_sel_n(spi_sel_n),
		.spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .rd_valid(rd_valid), .rd_data(rd_data));
	// ====================
	// Checking
	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_cnt(input int got, input int lo, input int hi, input string what);
		check_count++;
		if (got < lo || got > hi) begin
			num_errors++;
			$display("MISMATCH t=%0t %s got %0d exp %0d..%0d", $time, what, got, lo, hi);
		end
	endtask
	always @(posedge clock) begin
		if (rd_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				num_errors++;
				$display("MISMATCH t=%0t unexpected read", $time);
			end else begin
				e = exp_q.pop_front();
				chk_val(rd_data & e.mask, e.val, "read");
			end
		end
	end
	task automatic report_and_stop;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ====================
	// Stimulus helpers
	task automatic exp_rd(input logic [6:0] a, input logic [7:0] v, input logic [7:0] m);
		exp_q.push_back(rsc_exp_s'{val: v, mask: m});
		i_host.rd(a);
	endtask
	task automatic pulse(input logic [7:0] a, input logic [7:0] b, input logic d);
		@(posedge clock);
		ev_first <= a;
		ev_second <= b;
		tx_packet_done <= d;
		@(posedge clock);
		ev_first <= 8'h00;
		ev_second <= 8'h00;
		tx_packet_done <= 1'b0;
		@(negedge clock);
	endtask
	// Counts from the end of the write; the sequence already ran about 22 clocks by then
	task automatic meas(input logic rx, input int sum, input int cal);
		int n;
		int c;
		n = 0;
		c = 0;
		while (((rx ? modem_rx_en : modem_tx_en) !== 1'b1) && n < 5000) begin
			@(negedge clock);
			n++;
			if (vco_cal_en === 1'b1) begin
				c++;
			end
		end
		chk_cnt(n, sum - 30, sum + 5, "sequence cycles");
		chk_cnt(c, cal - 30, cal, "calibration cycles");
		chk_val({7'h00, rx ? rx_front_en : pa_en}, 8'h01, "front end on");
		chk_val({6'h00, power_state}, {6'h00, rx ? CPS_RX : CPS_TX}, "power state");
	endtask
	task automatic end_test(input string s);
		$display("test %s done", s);
	endtask
	initial begin
		#400000;
		num_errors++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		report_and_stop();
	end
	// ====================
	// Tests
	initial begin
		logic [31:0] f;
		sys_rst = 1'b1;
		ev_first = 8'h00;
		ev_second = 8'h00;
		fifo_flags = 5'h00;
		tx_packet_done = 1'b0;
		f = $urandom(77207);
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		@(negedge clock);
		chk_val({7'h00, interrupt_request_n}, 8'h00, "irq at reset");
		chk_val({7'h00, xtal_en}, 8'h01, "crystal on");
		exp_rd(ADDR_MASK_FIRST, MASK_FIRST_RST, 8'hff);
		exp_rd(ADDR_MASK_SECOND, MASK_SECOND_RST, 8'hff);
		exp_rd(ADDR_MODE_CTRL, MODE_CTRL_RST, 8'hff);
		exp_rd(ADDR_SEQ_CFG, SEQ_CFG_RST, 8'hff);
		exp_rd(ADDR_EV_SECOND, 8'h01, 8'h01);
		chk_val({7'h00, interrupt_request_n}, 8'h01, "irq released");
		exp_rd(ADDR_EV_SECOND, 8'h00, 8'h01);
		end_test("reset");
		for (int i = 0; i < 4; i++) begin
			f = $urandom;
			@(posedge clock);
			fifo_flags <= f[4:0];
			exp_rd(ADDR_DEV_STATUS, {f[4:0], 1'b0, CPS_IDLE}, 8'hff);
		end
		end_test("status");
		i_host.wr(ADDR_MASK_FIRST, 8'h04);
		pulse(8'h80, 8'h00, 1'b0);
		chk_val({7'h00, interrupt_request_n}, 8'h01, "masked event");
		pulse(8'h04, 8'h00, 1'b0);
		chk_val({7'h00, interrupt_request_n}, 8'h00, "enabled event");
		exp_rd(ADDR_EV_FIRST, 8'h84, 8'hff);
		chk_val({7'h00, interrupt_request_n}, 8'h01, "irq after read");
		i_host.wr(ADDR_EV_FIRST, 8'h00);
		exp_rd(ADDR_EV_FIRST, 8'h80, 8'hff);
		exp_rd(7'h50, 8'h00, 8'hff);
		end_test("events");
		i_host.wr(ADDR_MODE_CTRL, 8'h00);
		chk_val({7'h00, xtal_en}, 8'h00, "standby");
		chk_val({7'h00, ldo_main_en}, 8'h00, "standby regulator");
		i_host.wr(ADDR_MODE_CTRL, 8'h40);
		chk_val({7'h00, wake_timer_en}, 8'h01, "sleep");
		i_host.wr(ADDR_XTAL_CTRL, 8'h02);
		chk_val({7'h00, xtal_buf_override}, 8'h01, "buffer override");
		i_host.wr(ADDR_XTAL_CTRL, 8'h00);
		chk_val({7'h00, xtal_buf_override}, 8'h00, "buffer restore");
		i_host.wr(ADDR_MODE_CTRL, 8'h00);
		end_test("modes");
		i_host.wr(ADDR_MODE_CTRL, 8'h08);
		meas(1'b0, XC + 1 + VCO_CAL_CYC + PC + PA_RAMP_CYC, VCO_CAL_CYC);
		pulse(8'h00, 8'h00, 1'b1);
		chk_val({6'h00, power_state}, {6'h00, CPS_IDLE}, "tx end");
		chk_val({7'h00, interrupt_request_n}, 8'h00, "packet sent irq");
		exp_rd(ADDR_MODE_CTRL, 8'h00, 8'hff);
		exp_rd(ADDR_EV_FIRST, 8'h84, 8'hff);
		end_test("tx standby");
		i_host.wr(ADDR_MODE_CTRL, 8'h01);
		i_host.wr(ADDR_MODE_CTRL, 8'h09);
		meas(1'b0, 1 + VCO_CAL_CYC + PC + PA_RAMP_CYC, VCO_CAL_CYC);
		pulse(8'h00, 8'h00, 1'b1);
		i_host.wr(ADDR_SEQ_CFG, 8'h01);
		i_host.wr(ADDR_MODE_CTRL, 8'h09);
		meas(1'b0, 1 + PC + PA_RAMP_CYC, 0);
		pulse(8'h00, 8'h00, 1'b1);
		end_test("tx ready");
		i_host.wr(ADDR_MODE_CTRL, 8'h02);
		repeat (50) @(negedge clock);
		chk_val({7'h00, pll_en}, 8'h01, "tune pll");
		chk_val({7'h00, xtal_en}, 8'h01, "tune crystal");
		i_host.wr(ADDR_MODE_CTRL, 8'h06);
		meas(1'b1, 1, 0);
		chk_val({7'h00, rx_front_en}, 8'h01, "rx front end");
		i_host.wr(ADDR_MODE_CTRL, 8'h02);
		chk_val({6'h00, power_state}, {6'h00, CPS_IDLE}, "rx abort");
		end_test("tune rx");
		report_and_stop();
	end
endmodule
`default_nettype wire
